// ### rtl/link_cmd_pkg.sv
package link_cmd_pkg;

    localparam logic [7:0]  cmd_set_link       = 8'h09;
    localparam logic [7:0]  rsp_set_link       = 8'h89;
    localparam logic [15:0] resp_completed     = 16'h0000;
    localparam logic [15:0] resp_failed        = 16'h0001;
    localparam logic [15:0] reason_none        = 16'h0000;
    localparam logic [15:0] reason_bad_param   = 16'h0002;
    localparam logic [15:0] reason_host_confl  = 16'h0901;
    localparam logic [15:0] reason_speed_confl = 16'h0903;

    // Payload byte offsets within the command packet.
    localparam int          off_link_word      = 16;
    localparam int          off_vendor_word    = 20;
    localparam int          off_checksum       = 24;

    // Link settings word fields.
    localparam int          bit_autoneg        = 0;
    localparam int          lsb_speed          = 1;
    localparam int          msb_speed          = 7;
    localparam int          bit_half           = 8;
    localparam int          bit_full           = 9;
    localparam int          bit_pause_off      = 10;
    localparam int          bit_asym_pause     = 11;
    localparam int          bit_vendor_valid   = 12;
    localparam int          lsb_speed_ext      = 13;
    localparam int          msb_speed_ext      = 19;

    // Register map over APB, byte addresses.
    localparam logic [11:0] reg_ctrl           = 12'h000;
    localparam logic [11:0] reg_cmd_type       = 12'h004;
    localparam logic [11:0] reg_cmd_link       = 12'h008;
    localparam logic [11:0] reg_cmd_vendor     = 12'h00C;
    localparam logic [11:0] reg_caps           = 12'h010;
    localparam logic [11:0] reg_response       = 12'h014;
    localparam logic [11:0] reg_applied_link   = 12'h018;
    localparam logic [11:0] reg_applied_vendor = 12'h01C;
    localparam logic [11:0] reg_status         = 12'h020;

    // After reset, speeds 10M to 10G and both duplex modes are supported.
    localparam logic [31:0] caps_reset         = 32'h0000031E;

endpackage

// ### rtl/link_word_check.sv
`timescale 1ns/1ps
`default_nettype none
module link_word_check (
    input  wire logic [31:0] link_word,
    input  wire logic [31:0] caps,
    output logic             invalid,
    output logic             conflict
);
    logic        autoneg;
    logic [18:0] speeds;
    logic [18:0] sup_speeds;
    logic [1:0]  dup;
    logic [1:0]  sup_dup;
    logic        spd_one;
    logic        dup_one;

    always_comb begin
        autoneg    = link_word[link_cmd_pkg::bit_autoneg];
        speeds     = {link_word[link_cmd_pkg::msb_speed_ext:
                                link_cmd_pkg::lsb_speed_ext],
                      5'h0,
                      link_word[link_cmd_pkg::msb_speed:
                                link_cmd_pkg::lsb_speed]};
        sup_speeds = {caps[link_cmd_pkg::msb_speed_ext:
                           link_cmd_pkg::lsb_speed_ext],
                      5'h0,
                      caps[link_cmd_pkg::msb_speed:link_cmd_pkg::lsb_speed]};
        dup        = link_word[link_cmd_pkg::bit_full:link_cmd_pkg::bit_half];
        sup_dup    = caps[link_cmd_pkg::bit_full:link_cmd_pkg::bit_half];
        spd_one    = (speeds != 19'h0)
                     && ((speeds & (speeds - 19'h1)) == 19'h0);
        dup_one    = (dup == 2'h1) || (dup == 2'h2);
        // Forced mode needs exactly one supported speed and duplex.
        invalid    = !autoneg && (!spd_one || ((speeds & ~sup_speeds) != 19'h0)
                     || (dup_one && ((dup & ~sup_dup) != 2'h0))
                     || (dup == 2'h0));
        // Two duplex bits in forced mode give the speed-conflict reason.
        conflict   = !autoneg && (dup == 2'h3);
    end
endmodule
`default_nettype wire

// ### rtl/link_settings_command.sv
// Functional notes
// - Set-link command with no host driver reconfigures link.
// - Applied settings persist until host driver replaces them.
// - Apply change even if link drops.
// - Respond promptly, never wait for link completion.
// - Host driver governs; never restore after it stops.
// - Link word bytes 16-19, vendor word 20-23.
// - Bit 0 autoneg; several speeds offered together.
// - Bits 1-7 select speeds 10M to 40G.
// - Forced bad speed fails with invalid parameter.
// - Bit 8 half, bit 9 full duplex.
// - Forced bad duplex fails; two bits conflict.
// - Bit 10 set disables pause.
// - Bit 11 enables asymmetric pause.
// - Bit 12 gates the vendor word.
// - Accept valid command, respond with type 0x89.
// - Host driver operational gives reason 0x0901.
// - Autoneg ignores unsupported speeds and duplex.
// - Bits 13-19 select additional speeds.
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module link_settings_command (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        host_driver_up,
    input  wire logic        host_link_we,
    input  wire logic [31:0] host_link_word,
    output logic      [31:0] link_word,
    output logic      [31:0] vendor_word,
    output logic             link_apply,
    output logic             pause_enable,
    output logic             asym_pause,
    output logic             rsp_valid,
    output logic      [7:0]  rsp_type,
    output logic      [15:0] rsp_code,
    output logic      [15:0] rsp_reason
);
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic [7:0]  cmd_type;
        logic [31:0] cmd_link;
        logic [31:0] cmd_vendor;
        logic [31:0] caps;
        logic [31:0] link_word;
        logic [31:0] vendor_word;
        logic        link_apply;
        logic        pause_enable;
        logic        asym_pause;
        logic        rsp_valid;
        logic [7:0]  rsp_type;
        logic [15:0] rsp_code;
        logic [15:0] rsp_reason;
        logic        owned_by_host;
        logic [7:0]  cmd_count;
    } state_s;

    state_s st;
    state_s next_st;
    logic   chk_invalid;
    logic   chk_conflict;
    logic   access;
    logic   commit;
    logic   go;
    logic   pkt_ok;

    link_word_check u_check (
        .link_word (st.cmd_link),
        .caps      (st.caps),
        .invalid   (chk_invalid),
        .conflict  (chk_conflict)
    );

    always_comb begin
        next_st            = st;
        next_st.pready     = 1'b0;
        next_st.pslverr    = 1'b0;
        next_st.link_apply = 1'b0;
        next_st.rsp_valid  = 1'b0;
        // The first access cycle only schedules the answer, one wait state.
        access = psel && penable && !st.pready;
        // A write lands on the edge where the master sees pready high.
        // Refused writes never land, so pslverr also blocks the commit.
        commit = psel && penable && st.pready && pwrite && !st.pslverr;
        go     = 1'b0;
        pkt_ok = 1'b0;
        if (access) begin
            next_st.pready = 1'b1;
            next_st.prdata = 32'h0;
            if (pwrite) begin
                unique case (paddr)
                    link_cmd_pkg::reg_ctrl,
                    link_cmd_pkg::reg_cmd_type,
                    link_cmd_pkg::reg_cmd_link,
                    link_cmd_pkg::reg_cmd_vendor,
                    link_cmd_pkg::reg_caps:
                        next_st.pslverr = 1'b0;
                    default:
                        next_st.pslverr = 1'b1;
                endcase
            end else begin
                unique case (paddr)
                    link_cmd_pkg::reg_ctrl:       next_st.prdata = 32'h0;
                    link_cmd_pkg::reg_cmd_type:
                        next_st.prdata = {24'h0, st.cmd_type};
                    link_cmd_pkg::reg_cmd_link:   next_st.prdata = st.cmd_link;
                    link_cmd_pkg::reg_cmd_vendor:
                        next_st.prdata = st.cmd_vendor;
                    link_cmd_pkg::reg_caps:       next_st.prdata = st.caps;
                    link_cmd_pkg::reg_response:
                        next_st.prdata = {st.rsp_code, st.rsp_reason};
                    link_cmd_pkg::reg_applied_link:
                        next_st.prdata = st.link_word;
                    link_cmd_pkg::reg_applied_vendor:
                        next_st.prdata = st.vendor_word;
                    link_cmd_pkg::reg_status:
                        next_st.prdata = {16'h0, st.cmd_count, 6'h0,
                                          st.owned_by_host, host_driver_up};
                    default:                      next_st.pslverr = 1'b1;
                endcase
            end
        end

        if (commit) begin
            unique case (paddr)
                link_cmd_pkg::reg_ctrl: begin
                    go     = pwdata[0];
                    // Software signals header and checksum passed.
                    pkt_ok = pwdata[1];
                end
                link_cmd_pkg::reg_cmd_type:
                    next_st.cmd_type = pwdata[7:0];
                // Payload words are taken from bytes 16-19, 20-23.
                link_cmd_pkg::reg_cmd_link:
                    next_st.cmd_link = pwdata;
                link_cmd_pkg::reg_cmd_vendor:
                    next_st.cmd_vendor = pwdata;
                link_cmd_pkg::reg_caps:
                    next_st.caps = pwdata;
                default:
                    go = 1'b0;
            endcase
        end

        // The running host driver owns the link; its writes replace ours.
        if (host_driver_up && host_link_we) begin
            next_st.link_word     = host_link_word;
            next_st.owned_by_host = 1'b1;
            next_st.link_apply    = 1'b1;
        end

        // Invalid packets are dropped silently with no response.
        if (go && pkt_ok && st.cmd_type == link_cmd_pkg::cmd_set_link) begin
            // Answered next cycle; link bring-up is never awaited.
            next_st.rsp_valid = 1'b1;
            next_st.rsp_type  = link_cmd_pkg::rsp_set_link;
            next_st.cmd_count = st.cmd_count + 8'h1;
            if (host_driver_up) begin
                // Leave the link alone while the host driver runs.
                next_st.rsp_code   = link_cmd_pkg::resp_failed;
                next_st.rsp_reason = link_cmd_pkg::reason_host_confl;
            end else if (chk_conflict) begin
                next_st.rsp_code   = link_cmd_pkg::resp_failed;
                next_st.rsp_reason = link_cmd_pkg::reason_speed_confl;
            end else if (chk_invalid) begin
                next_st.rsp_code   = link_cmd_pkg::resp_failed;
                next_st.rsp_reason = link_cmd_pkg::reason_bad_param;
            end else begin
                next_st.rsp_code   = link_cmd_pkg::resp_completed;
                next_st.rsp_reason = link_cmd_pkg::reason_none;
                // Unsupported bits are masked off under autoneg.
                // Speeds sit in bits 1-7 and 13-19.
                // Duplex bits 8-9 pass when supported.
                // Control bits 0 and 10-12 are never masked.
                if (st.cmd_link[link_cmd_pkg::bit_autoneg])
                    next_st.link_word = st.cmd_link & (st.caps | 32'hFFF01C01);
                else
                    next_st.link_word = st.cmd_link;
                // The pulse renegotiates even if the link drops.
                next_st.link_apply    = 1'b1;
                next_st.owned_by_host = 1'b0;
                // Pause bit has inverted sense; forced mode assumes partner.
                next_st.pause_enable =
                    !st.cmd_link[link_cmd_pkg::bit_pause_off];
                next_st.asym_pause   =
                    st.cmd_link[link_cmd_pkg::bit_asym_pause];
                // The vendor word is only taken when flagged valid.
                if (st.cmd_link[link_cmd_pkg::bit_vendor_valid])
                    next_st.vendor_word = st.cmd_vendor;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st      <= '0;
            st.caps <= link_cmd_pkg::caps_reset;
        end else begin
            st <= next_st;
        end
    end

    assign prdata       = st.prdata;
    assign pready       = st.pready;
    assign pslverr      = st.pslverr;
    assign link_word    = st.link_word;
    assign vendor_word  = st.vendor_word;
    assign link_apply   = st.link_apply;
    assign pause_enable = st.pause_enable;
    assign asym_pause   = st.asym_pause;
    assign rsp_valid    = st.rsp_valid;
    assign rsp_type     = st.rsp_type;
    assign rsp_code     = st.rsp_code;
    assign rsp_reason   = st.rsp_reason;
endmodule
`default_nettype wire

// ### sim/link_cmd_sva.sv
`timescale 1ns/1ps
`default_nettype none
module link_cmd_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        host_driver_up,
    input wire logic        host_link_we,
    input wire logic [31:0] link_word,
    input wire logic        link_apply,
    input wire logic        pause_enable,
    input wire logic        asym_pause,
    input wire logic        rsp_valid,
    input wire logic [7:0]  rsp_type,
    input wire logic [15:0] rsp_code,
    input wire logic [15:0] rsp_reason
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr alone");
    a_rsp_type: assert property (rsp_valid |-> rsp_type == 8'h89)
        else $error("bad response type");
    a_host_refuse: assert property (rsp_valid && $past(host_driver_up)
        |-> rsp_reason == 16'h0901 && !link_apply) else $error("host case");
    a_apply_ok: assert property (link_apply && !$past(host_link_we)
        |-> rsp_valid && rsp_code == link_cmd_pkg::resp_completed)
        else $error("apply");
    // A link word change needs a command or a host driver write behind it.
    a_word_held: assert property ($changed(link_word) |-> link_apply
        || ($past(host_link_we) && $past(host_driver_up)))
        else $error("link word moved");
    a_pause_map: assert property (link_apply && rsp_valid |->
        pause_enable == !link_word[10] && asym_pause == link_word[11])
        else $error("pause mapping");
    c_apply: cover property (link_apply);
    c_fail: cover property (rsp_valid && rsp_code == 16'h0001);
    c_err: cover property (pslverr);
endmodule
bind link_settings_command link_cmd_sva chk (
    .pclk           (pclk),
    .presetn        (presetn),
    .psel           (psel),
    .penable        (penable),
    .pready         (pready),
    .pslverr        (pslverr),
    .host_driver_up (host_driver_up),
    .host_link_we   (host_link_we),
    .link_word      (link_word),
    .link_apply     (link_apply),
    .pause_enable   (pause_enable),
    .asym_pause     (asym_pause),
    .rsp_valid      (rsp_valid),
    .rsp_type       (rsp_type),
    .rsp_code       (rsp_code),
    .rsp_reason     (rsp_reason)
);
`default_nettype wire

// ### sim/mgmt_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module mgmt_ctrl_model (
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    output logic             hang
);
    initial begin
        {psel, penable, pwrite, hang, paddr, pwdata} = '0;
    end
    // The request is held until pready for at most 16 cycles; a slave still not ready by then raises hang.
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (!pready && n < 16);
        hang <= hang | !pready;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ### sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        host_driver_up = 1'b0;
    logic        host_link_we = 1'b0;
    logic [31:0] host_link_word = 32'h0;
    logic        psel, penable, pwrite, pready, pslverr, hang, e;
    logic        link_apply, pause_enable, asym_pause, rsp_valid;
    logic [7:0]  rsp_type;
    logic [11:0] paddr;
    logic [15:0] rsp_code, rsp_reason;
    logic [31:0] pwdata, prdata, link_word, vendor_word, q;
    int          failures = 0;
    int          samples_checked = 0;
    always #5 pclk = ~pclk;
    link_settings_command dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .host_driver_up(host_driver_up), .host_link_we(host_link_we),
        .host_link_word(host_link_word), .link_word(link_word),
        .vendor_word(vendor_word), .link_apply(link_apply),
        .pause_enable(pause_enable), .asym_pause(asym_pause),
        .rsp_valid(rsp_valid), .rsp_type(rsp_type), .rsp_code(rsp_code),
        .rsp_reason(rsp_reason));
    mgmt_ctrl_model mc (.pclk(pclk), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .hang(hang));
    task automatic chk(input string n, input logic [31:0] s, x);
        samples_checked++;
        if (s !== x) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Returns in the one cycle where the response pulse stands.
    task automatic cmd(input logic [7:0] t, input logic [31:0] lw, vw, c);
        mc.xfer(1'b1, link_cmd_pkg::reg_cmd_type, {24'h0, t}, q, e);
        mc.xfer(1'b1, link_cmd_pkg::reg_cmd_link, lw, q, e);
        mc.xfer(1'b1, link_cmd_pkg::reg_cmd_vendor, vw, q, e);
        mc.xfer(1'b1, link_cmd_pkg::reg_ctrl, c, q, e);
        #1;
    endtask
    task automatic rsp(input logic [15:0] c, r, input logic ap);
        chk("rsp_valid", rsp_valid, 1'h1);
        chk("rsp_type", rsp_type, link_cmd_pkg::rsp_set_link);
        chk("rsp_code", rsp_code, c);
        chk("rsp_reason", rsp_reason, r);
        chk("link_apply", link_apply, ap);
    endtask
    task automatic t_regs();
        mc.xfer(1'b0, link_cmd_pkg::reg_caps, 32'h0, q, e);
        chk("caps", q, 32'h0000031E);
        mc.xfer(1'b0, 12'h024, 32'h0, q, e);
        chk("unmapped_err", e, 1'h1);
        chk("unmapped_data", q, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_autoneg();
        cmd(8'h09, 32'h00003FFF, 32'hA5A55A5A, 32'h3);
        rsp(16'h0, 16'h0, 1'h1);
        chk("masked", link_word, 32'h00001F1F);
        chk("vendor", vendor_word, 32'hA5A55A5A);
        chk("pause", pause_enable, 1'h0);
        chk("asym", asym_pause, 1'h1);
        $display("test autoneg done");
    endtask
    task automatic t_forced();
        logic [31:0] w [5] = '{32'h204, 32'h206, 32'h280, 32'h304, 32'h4};
        logic [15:0] r [5] = '{16'h0, 16'h2, 16'h2, 16'h903, 16'h2};
        for (int i = 0; i < 5; i++) begin
            cmd(8'h09, w[i], 32'h12345678, 32'h3);
            rsp(r[i] == 16'h0 ? 16'h0 : 16'h1, r[i], r[i] == 16'h0);
            chk("forced", link_word, 32'h204);
            chk("vendor_kept", vendor_word, 32'hA5A55A5A);
            chk("pause_on", pause_enable, 1'h1);
        end
        $display("test forced done");
    endtask
    task automatic t_host();
        @(posedge pclk);
        host_driver_up <= 1'b1;
        cmd(8'h09, 32'h3, 32'h0, 32'h3);
        rsp(16'h1, 16'h0901, 1'h0);
        chk("host_keep", link_word, 32'h204);
        @(posedge pclk);
        host_link_we <= 1'b1;
        host_link_word <= 32'h211;
        @(posedge pclk);
        host_link_we <= 1'b0;
        host_driver_up <= 1'b0;
        repeat (3) @(posedge pclk);
        #1 chk("host_word", link_word, 32'h211);
        $display("test host done");
    endtask
    task automatic t_invalid();
        cmd(8'h09, 32'h3, 32'h0, 32'h1);
        chk("no_rsp_ctl", rsp_valid, 1'h0);
        cmd(8'h05, 32'h3, 32'h0, 32'h3);
        chk("no_rsp_type", rsp_valid, 1'h0);
        chk("kept", link_word, 32'h211);
        $display("test invalid done");
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        chk("link_reset", link_word, 32'h0);
        t_regs();
        t_autoneg();
        t_forced();
        t_host();
        t_invalid();
        summarize();
    end
    always @(posedge hang) begin
        failures++;
        summarize();
    end
endmodule
`default_nettype wire
